// file: tpc_timer.sv
// tpc_timer: 16-bit free-running timer with two capture/compare channels,
// pulse output with polarity, emergency stop and an APB register file.
// assumes all pins synchronous to core_clk; pad logic resolves the pin.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tpc_timer
    import tpc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int DIV_W = 8
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external inputs
    input wire logic chan0_trigger_in,
    input wire logic chan1_trigger_in,
    input wire logic emergency_stop_in,
    // pulse output pin
    output logic pulse_out_pin,
    output logic pulse_out_oe,
    // events
    output logic chan0_irq,
    output logic chan1_irq,
    output logic overflow_irq
);
    if (CNT_W != 16 || DIV_W < 8 || DIV_W > 16)
        $error("tpc_timer: unsupported CNT_W or DIV_W");

    // ----------------------------------------------------------------
    // registers and declarations
    // ----------------------------------------------------------------
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [1:0] xirq_q;
    logic [3:0] cedge_q;
    logic [1:0] pin_q;
    logic ostop_en_q;
    logic stop_latch_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cc_q [2];
    logic fresh_q;
    logic run_q;
    logic [DIV_W-1:0] div_q;
    logic active_q;
    logic [1:0] chan_irq_q;
    logic ovf_irq_q;
    logic out_q;
    logic oe_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic wr;
    logic rd;
    logic cse;
    logic ce;
    logic tick;
    logic step;
    logic [1:0] cmp_mode;
    logic [1:0] match;
    logic [1:0] cap_edge;
    logic clr_match;
    logic wrap;
    logic ovf_evt;
    logic stop_edge;
    logic out_mode;
    logic [DIV_W-1:0] div_mask;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign wr = psel && penable && pready_q && pwrite;
    assign rd = psel && penable && pready_q && !pwrite;
    assign cse = ctrl0_q[TPC_C0_CSE];
    assign ce = ctrl0_q[TPC_C0_CE];
    // each channel follows its own mode bit: 1 compare, 0 capture
    assign cmp_mode = {ctrl1_q[TPC_C1_MS1], ctrl1_q[TPC_C1_MS0]};
    assign out_mode = pin_q[TPC_PIN_MODE] && pin_q[TPC_PIN_FUNC];

    // ----------------------------------------------------------------
    // count clock
    // ----------------------------------------------------------------
    // the select field picks a power-of-two divide of core_clk
    assign div_mask = DIV_W'((DIV_W'(1) << ctrl0_q[TPC_C0_CS_LO +: 3]) - DIV_W'(1));
    assign tick = (div_q & div_mask) == '0;
    assign step = cse && ce && run_q && tick;

    always_ff @(posedge core_clk)
    begin
        if (srst || !cse || !ce)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end

    // ----------------------------------------------------------------
    // main counter
    // ----------------------------------------------------------------
    // 0000h reached by a clear or by starting is never a match
    genvar gi;
    for (gi = 0; gi < 2; gi++)
    begin : g_match
        assign match[gi] = step && cmp_mode[gi] && fresh_q && (cnt_q == cc_q[gi]);
    end
    assign clr_match = match[0] && ctrl1_q[TPC_C1_MATCH_CLEAR_ENABLE];
    assign wrap = step && (cnt_q == TPC_CNT_MAX);
    assign ovf_evt = wrap && !clr_match;

    always_ff @(posedge core_clk)
    begin
        if (srst || !cse)
        begin
            cnt_q <= TPC_CNT_ZERO;
            fresh_q <= 1'b0;
        end
        else if (!ce)
        begin
            // stopping by the enable is a clear, not an overflow
            cnt_q <= TPC_CNT_ZERO;
            fresh_q <= 1'b0;
        end
        else if (step)
        begin
            if (clr_match)
            begin
                cnt_q <= TPC_CNT_ZERO;
                fresh_q <= 1'b0;
            end
            else
            begin
                cnt_q <= cnt_q + CNT_W'(1);
                fresh_q <= 1'b1;
            end
        end
    end

    // overflow halt; restarted by writing the count enable to 1 or by clearing cse
    always_ff @(posedge core_clk)
    begin
        if (srst || !cse)
            run_q <= 1'b1;
        else if (wr && paddr == TPC_OFS_CTRL0 && pwdata[TPC_C0_CE])
            run_q <= 1'b1;
        else if (ovf_evt && ctrl1_q[TPC_C1_OST])
            run_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // capture/compare channels
    // ----------------------------------------------------------------
    tpc_edge_det u_cap0 (
        .core_clk(core_clk),
        .srst(srst),
        .clr(!cse),
        .tick(tick),
        .sig(chan0_trigger_in),
        .edge_sel(cedge_q[1:0]),
        .edge_pulse(cap_edge[0])
    );

    tpc_edge_det u_cap1 (
        .core_clk(core_clk),
        .srst(srst),
        .clr(!cse),
        .tick(tick),
        .sig(chan1_trigger_in),
        .edge_sel(cedge_q[3:2]),
        .edge_pulse(cap_edge[1])
    );

    for (gi = 0; gi < 2; gi++)
    begin : g_chan
        logic cap_ok;
        logic rd_self;
        assign cap_ok = !cmp_mode[gi] && ce && run_q && cap_edge[gi];
        assign rd_self = rd && (paddr == (gi == 0 ? TPC_OFS_CH0 : TPC_OFS_CH1));

        always_ff @(posedge core_clk)
        begin
            if (srst || !cse)
                cc_q[gi] <= TPC_CNT_ZERO;
            else if (cap_ok && !rd_self)
                cc_q[gi] <= cnt_q;
            else if (wr && paddr == (gi == 0 ? TPC_OFS_CH0 : TPC_OFS_CH1))
                cc_q[gi] <= pwdata[CNT_W-1:0];
        end

        always_ff @(posedge core_clk)
        begin
            if (srst || !cse)
                chan_irq_q[gi] <= 1'b0;
            else
                chan_irq_q[gi] <= cmp_mode[gi] ? match[gi] : cap_ok;
        end
    end

    // ----------------------------------------------------------------
    // pulse output and emergency stop
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst || !cse)
            active_q <= 1'b0;
        else if (match[1])
            active_q <= 1'b0;
        else if (match[0])
            active_q <= 1'b1;
    end

    tpc_edge_det u_stop (
        .core_clk(core_clk),
        .srst(srst),
        .clr(1'b0),
        .tick(1'b1),
        .sig(emergency_stop_in),
        .edge_sel(xirq_q),
        .edge_pulse(stop_edge)
    );

    always_ff @(posedge core_clk)
    begin
        if (srst)
            stop_latch_q <= 1'b0;
        else if (out_mode && ostop_en_q && stop_edge)
            stop_latch_q <= 1'b1;
        else if (!ostop_en_q)
            stop_latch_q <= 1'b0;
    end

    // glitches on simultaneous enable/polarity writes are avoided by
    // registering the pin, but software still must not rely on that
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            out_q <= 1'b1;
            oe_q <= 1'b0;
        end
        else
        begin
            out_q <= (ctrl1_q[TPC_C1_ENT] && active_q) ? ctrl1_q[TPC_C1_ALV]
                : !ctrl1_q[TPC_C1_ALV];
            oe_q <= out_mode && !stop_latch_q;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl0_q <= TPC_CTRL_RST;
            ctrl1_q <= TPC_CTRL_RST;
            xirq_q <= TPC_EDGE_FALL;
            cedge_q <= '0;
            pin_q <= '0;
            ostop_en_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == TPC_OFS_CTRL0)
            begin
                ctrl0_q[6:0] <= pwdata[6:0];
                ctrl0_q[TPC_C0_OVF] <= ovf_evt || (ctrl0_q[TPC_C0_OVF] && pwdata[TPC_C0_OVF]);
            end
            else if (ovf_evt)
                ctrl0_q[TPC_C0_OVF] <= 1'b1;
            if (wr && paddr == TPC_OFS_CTRL1)
                ctrl1_q <= pwdata[7:0];
            if (wr && paddr == TPC_OFS_XIRQ)
                xirq_q <= pwdata[1:0];
            if (wr && paddr == TPC_OFS_CEDGE)
                cedge_q <= pwdata[3:0];
            if (wr && paddr == TPC_OFS_PIN)
                pin_q <= pwdata[1:0];
            if (wr && paddr == TPC_OFS_OSTOP)
                ostop_en_q <= pwdata[TPC_OS_EN];
        end
    end

    always_comb
    begin
        rd_mux = '0;
        rd_hit = 1'b1;
        unique case (paddr)
            TPC_OFS_CTRL0: rd_mux[7:0] = ctrl0_q;
            TPC_OFS_CTRL1: rd_mux[7:0] = ctrl1_q;
            TPC_OFS_CH0: rd_mux[CNT_W-1:0] = cc_q[0];
            TPC_OFS_CH1: rd_mux[CNT_W-1:0] = cc_q[1];
            TPC_OFS_COUNT: rd_mux[CNT_W-1:0] = cnt_q;
            TPC_OFS_OSTOP: rd_mux[1:0] = {stop_latch_q, ostop_en_q};
            TPC_OFS_XIRQ: rd_mux[1:0] = xirq_q;
            TPC_OFS_CEDGE: rd_mux[3:0] = cedge_q;
            TPC_OFS_PIN: rd_mux[1:0] = pin_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // no wait state: data is sampled in the setup cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !rd_hit;
            prdata_q <= (psel && !penable && !pwrite) ? rd_mux : '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst || !cse)
            ovf_irq_q <= 1'b0;
        else
            ovf_irq_q <= ovf_evt;
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pulse_out_pin = out_q;
    assign pulse_out_oe = oe_q;
    assign chan0_irq = chan_irq_q[0];
    assign chan1_irq = chan_irq_q[1];
    assign overflow_irq = ovf_irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_set_on_match0;
        @(posedge core_clk) disable iff (srst)
        (match[0] && !match[1]) |=> active_q;
    endproperty
    a_set_on_match0: assert property (p_set_on_match0) else $error("no set on match0");

    property p_equal_inactive;
        @(posedge core_clk) disable iff (srst)
        (match[0] && match[1]) |=> !active_q;
    endproperty
    a_equal_inactive: assert property (p_equal_inactive) else $error("equal match not inactive");

    property p_level;
        @(posedge core_clk) disable iff (srst)
        (ctrl1_q[TPC_C1_ENT] && active_q) |=> (out_q == $past(ctrl1_q[TPC_C1_ALV]));
    endproperty
    a_level: assert property (p_level) else $error("wrong active level");

    property p_disabled;
        @(posedge core_clk) disable iff (srst)
        !ctrl1_q[TPC_C1_ENT] |=> (out_q != $past(ctrl1_q[TPC_C1_ALV]));
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled level wrong");

    property p_stop_float;
        @(posedge core_clk) disable iff (srst)
        (out_mode && ostop_en_q && stop_edge) |=> ##1 !oe_q;
    endproperty
    a_stop_float: assert property (p_stop_float) else $error("stop edge ignored");

    property p_stop_release;
        @(posedge core_clk) disable iff (srst)
        (stop_latch_q && !ostop_en_q && out_mode) ##1 out_mode |=> oe_q;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop not released");

    property p_clr_zero;
        @(posedge core_clk) disable iff (srst)
        clr_match |=> (cnt_q == TPC_CNT_ZERO) && chan0_irq;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("match clear failed");

    property p_wrap;
        @(posedge core_clk) disable iff (srst)
        ovf_evt |=> (cnt_q == TPC_CNT_ZERO) && ctrl0_q[TPC_C0_OVF] && overflow_irq;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow not flagged");

    property p_capture;
        @(posedge core_clk) disable iff (srst)
        (g_chan[0].cap_ok && !g_chan[0].rd_self) |=> (cc_q[0] == $past(cnt_q)) && chan0_irq;
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    property p_read_hold;
        @(posedge core_clk) disable iff (srst)
        (g_chan[1].cap_ok && g_chan[1].rd_self) |=> $stable(cc_q[1]) && chan1_irq;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("capture during read");

    property p_cse_reset;
        @(posedge core_clk) disable iff (srst)
        !cse |=> (cnt_q == TPC_CNT_ZERO) && !active_q;
    endproperty
    a_cse_reset: assert property (p_cse_reset) else $error("not held reset");

    c_pwm: cover property (@(posedge core_clk) disable iff (srst) match[0] ##[1:300] match[1]);
    c_capture: cover property (@(posedge core_clk) disable iff (srst) g_chan[0].cap_ok);
    c_stop: cover property (@(posedge core_clk) disable iff (srst) stop_latch_q ##1 !stop_latch_q);
    c_ovf: cover property (@(posedge core_clk) disable iff (srst) ovf_evt);
endmodule
`default_nettype wire

// file: tpc_pkg.sv
// tpc_pkg: register map, field positions and reset values of the
// timer pulse/capture unit.
// assumes a 32-bit APB slave with one register per aligned word.
package tpc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] TPC_OFS_CTRL0 = 8'h00;
    localparam logic [7:0] TPC_OFS_CTRL1 = 8'h04;
    localparam logic [7:0] TPC_OFS_CH0 = 8'h08;
    localparam logic [7:0] TPC_OFS_CH1 = 8'h0c;
    localparam logic [7:0] TPC_OFS_COUNT = 8'h10;
    localparam logic [7:0] TPC_OFS_OSTOP = 8'h14;
    localparam logic [7:0] TPC_OFS_XIRQ = 8'h18;
    localparam logic [7:0] TPC_OFS_CEDGE = 8'h1c;
    localparam logic [7:0] TPC_OFS_PIN = 8'h20;
    // ----------------------------------------------------------------
    // timer_control_primary fields
    // ----------------------------------------------------------------
    localparam int TPC_C0_CSE = 0;
    localparam int TPC_C0_CE = 1;
    localparam int TPC_C0_CS_LO = 4;
    localparam int TPC_C0_OVF = 7;
    // ----------------------------------------------------------------
    // timer_control_secondary fields
    // ----------------------------------------------------------------
    localparam int TPC_C1_MS0 = 0;
    localparam int TPC_C1_MS1 = 1;
    localparam int TPC_C1_MATCH_CLEAR_ENABLE = 3;
    localparam int TPC_C1_ALV = 5;
    localparam int TPC_C1_ENT = 6;
    localparam int TPC_C1_OST = 7;
    // ----------------------------------------------------------------
    // other fields, reset values and edge codes
    // ----------------------------------------------------------------
    localparam int TPC_OS_EN = 0;
    localparam int TPC_OS_LATCH = 1;
    localparam int TPC_PIN_MODE = 0;
    localparam int TPC_PIN_FUNC = 1;
    localparam logic [7:0] TPC_CTRL_RST = 8'h00;
    localparam logic [15:0] TPC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TPC_CNT_MAX = 16'hffff;
    localparam logic [1:0] TPC_EDGE_FALL = 2'h0;
    localparam logic [1:0] TPC_EDGE_RISE = 2'h1;
    localparam logic [1:0] TPC_EDGE_NONE = 2'h2;
    localparam logic [1:0] TPC_EDGE_BOTH = 2'h3;
    localparam int TPC_FILT_SAMPLES = 2;
endpackage

// file: tpc_edge_det.sv
// tpc_edge_det: sampled edge detector with a two-sample stability filter.
// assumes sig is synchronous to core_clk; tick paces the sampling.
`timescale 1ns/100ps
`default_nettype none
module tpc_edge_det
    import tpc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clr,
    // sampling
    input wire logic tick,
    input wire logic sig,
    input wire logic [1:0] edge_sel,
    // result
    output logic edge_pulse
);
    logic [TPC_FILT_SAMPLES-1:0] smp_q;
    logic stable_q;
    logic settled;
    logic rise;
    logic fall;

    // a new level counts only after it held for two sample ticks
    assign settled = (smp_q == {TPC_FILT_SAMPLES{smp_q[0]}}) && (smp_q[0] != stable_q);
    assign rise = tick && settled && smp_q[0];
    assign fall = tick && settled && !smp_q[0];

    always_ff @(posedge core_clk)
    begin
        if (srst || clr)
        begin
            smp_q <= '0;
            stable_q <= 1'b0;
        end
        else if (tick)
        begin
            smp_q <= {smp_q[TPC_FILT_SAMPLES-2:0], sig};
            if (settled)
                stable_q <= smp_q[0];
        end
    end

    always_comb
    begin
        unique case (edge_sel)
            TPC_EDGE_FALL: edge_pulse = fall;
            TPC_EDGE_RISE: edge_pulse = rise;
            TPC_EDGE_NONE: edge_pulse = 1'b0;
            TPC_EDGE_BOTH: edge_pulse = rise || fall;
        endcase
    end
endmodule
`default_nettype wire

// file: tpc_stage_model.sv
// tpc_stage_model: power stage and pulse sources on the far side of tpc_timer.
// assumes callers enter pulse right after a core_clk rising edge.
`timescale 1ns/100ps
`default_nettype none
module tpc_stage_model
(
    // clock
    input wire logic core_clk,
    // pin from the timer
    input wire logic pin,
    input wire logic oe,
    // lines into the timer
    output logic trig0,
    output logic trig1,
    output logic estop,
    // level seen by the stage
    output logic line
);
    logic last_q = 1'b1;
    initial
    begin
        trig0 = 1'b0;
        trig1 = 1'b0;
        estop = 1'b0;
    end
    // no pull on the pin: a floating line shows the inverse of the last drive
    always @(posedge core_clk)
        if (oe === 1'b1)
            last_q <= pin;
    assign line = (oe === 1'b1) ? pin : ~last_q;
    task automatic set(input int idx, input logic v);
        case (idx)
            0: trig0 <= v;
            1: trig1 <= v;
            default: estop <= v;
        endcase
    endtask
    // shorter levels may be missed by the filter, so widths are clamped
    task automatic pulse(input int idx, input int width);
        int w;
        w = (width < 3) ? 3 : width;
        set(idx, 1'b1);
        repeat (w) @(posedge core_clk);
        set(idx, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// tb: apb-level tests of tpc_timer with expected values from the register map.
// assumes tpc_stage_model drives the trigger and stop inputs.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tpc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic t0, t1, es, pin, oe, irq0, irq1, ovf, line;
    logic [31:0] rd;
    logic err;
    logic [2:0] ev;
    int n_errors = 0;
    int n_compared = 0;
    int n0 = 0;
    int n1 = 0;
    int a, b, s0, s1, e;
    int codes[4] = '{0, 1, 3, 2};
    assign ev = {ovf, irq1, irq0};
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (irq0 === 1'b1)
            n0 <= n0 + 1;
        if (irq1 === 1'b1)
            n1 <= n1 + 1;
    end
    tpc_timer #(.CNT_W(16), .DIV_W(8)) dut (.core_clk(core_clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan0_trigger_in(t0), .chan1_trigger_in(t1), .emergency_stop_in(es),
        .pulse_out_pin(pin), .pulse_out_oe(oe), .chan0_irq(irq0),
        .chan1_irq(irq1), .overflow_irq(ovf));
    tpc_stage_model drv (.core_clk(core_clk), .pin(pin), .oe(oe), .trig0(t0),
        .trig1(t1), .estop(es), .line(line));
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one idle cycle after each transfer keeps psel from two writes per step
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50)
            chk("pready", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task rdc(input string what, input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(what, exp, rd);
    endtask
    task wev(input int bit_i, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (ev[bit_i] !== 1'b1 && k < lim);
        chk("event", 1, k < lim);
    endtask
    task done(input string what);
        $display("test %s done", what);
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        // the overflow wait dominates: about 65600 cycles plus a few thousand
        repeat (90000) @(posedge core_clk);
        n_errors++;
        results;
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk("pin", 1, pin);
        chk("oe", 0, oe);
        rdc("ctrl1", TPC_OFS_CTRL1, 0);
        rdc("unmapped", 8'h24, 0);
        chk("slverr", 1, err);
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_PIN, 3);
        repeat (2) @(posedge core_clk);
        chk("oe", 1, oe);
        for (int v = 0; v < 2; v++)
        begin
            wr(TPC_OFS_CTRL1, v << 5);
            repeat (3) @(posedge core_clk);
            chk("pin", !v, pin);
        end
        wr(TPC_OFS_CTRL1, 3);
        wr(TPC_OFS_CH0, 32'h1234);
        rdc("ch0", TPC_OFS_CH0, 32'h1234);
        wr(TPC_OFS_CTRL0, 0);
        wr(TPC_OFS_CTRL0, 1);
        rdc("ch0", TPC_OFS_CH0, 0);
        done("registers");
        for (int v = 0; v < 2; v++)
        begin
            wr(TPC_OFS_CTRL0, 1);
            wr(TPC_OFS_CTRL1, 32'h43 | (v << 5));
            wr(TPC_OFS_CH0, 32'h40);
            wr(TPC_OFS_CH1, 32'h80);
            wr(TPC_OFS_CTRL0, 3);
            wev(0, 200, a);
            repeat (3) @(posedge core_clk);
            chk("line", v, line);
            wev(1, 200, a);
            repeat (3) @(posedge core_clk);
            chk("line", !v, line);
        end
        wev(2, 70000, a);
        rdc("ctrl0", TPC_OFS_CTRL0, 32'h83);
        wev(0, 200, a);
        done("pwm");
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_CTRL1, 32'h43);
        wr(TPC_OFS_CH1, 32'h40);
        wr(TPC_OFS_CTRL0, 3);
        wev(0, 200, a);
        repeat (3) @(posedge core_clk);
        chk("line", 1, line);
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_CTRL1, 32'h0b);
        wr(TPC_OFS_CH0, 32'h20);
        wr(TPC_OFS_CTRL0, 3);
        wev(0, 200, a);
        wev(0, 200, a);
        wev(0, 200, b);
        chk("period", a, b);
        chk("short", 1, a < 40);
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_CTRL0, 32'h13);
        wev(0, 200, a);
        wev(0, 200, b);
        chk("period2", 66, b);
        done("match");
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_CTRL1, 0);
        foreach (codes[i])
        begin
            wr(TPC_OFS_CEDGE, codes[i] | (codes[i] << 2));
            wr(TPC_OFS_CTRL0, 3);
            s0 = n0;
            s1 = n1;
            e = (codes[i] == 3) ? 2 : (codes[i] == 2) ? 0 : 1;
            drv.pulse(0, 8);
            drv.pulse(1, 8);
            repeat (10) @(posedge core_clk);
            chk("cap0", e, n0 - s0);
            chk("cap1", e, n1 - s1);
            wr(TPC_OFS_CTRL0, 1);
        end
        wr(TPC_OFS_CEDGE, 32'h05);
        wr(TPC_OFS_CTRL0, 3);
        drv.pulse(0, 10);
        repeat (90) @(posedge core_clk);
        drv.pulse(1, 10);
        repeat (10) @(posedge core_clk);
        apb(1'b0, TPC_OFS_CH0, 0);
        a = rd;
        apb(1'b0, TPC_OFS_CH1, 0);
        chk("cycle", 100, rd - a);
        // rising edge lands on the access cycle of the channel 1 read
        a = rd;
        s1 = n1;
        drv.set(1, 1'b1);
        @(posedge core_clk);
        rdc("ch1 read", TPC_OFS_CH1, a);
        rdc("ch1 hold", TPC_OFS_CH1, a);
        chk("cap1 irq", 1, n1 - s1);
        drv.set(1, 1'b0);
        done("capture");
        wr(TPC_OFS_CTRL0, 1);
        wr(TPC_OFS_OSTOP, 1);
        foreach (codes[i])
        begin
            wr(TPC_OFS_XIRQ, codes[i]);
            drv.pulse(2, 6);
            repeat (8) @(posedge core_clk);
            chk("oe", codes[i] == 2, oe);
            if (codes[i] != 2)
                rdc("ostop", TPC_OFS_OSTOP, 3);
            wr(TPC_OFS_OSTOP, 0);
            repeat (3) @(posedge core_clk);
            chk("oe", 1, oe);
            wr(TPC_OFS_OSTOP, 1);
        end
        done("stop");
        results;
    end
endmodule
`default_nettype wire
